// ---- hdl/servo_ctrl_pkg.sv ----
// Package: register map, field values, reset values and timing counts
`default_nettype none
package servo_ctrl_pkg;
  // Register offsets (word index on the plain register port)
  localparam logic [3:0] REG_MODE     = 4'h0;
  localparam logic [3:0] REG_CARRIER  = 4'h1;
  localparam logic [3:0] REG_ILIM     = 4'h2;
  localparam logic [3:0] REG_PEAK8    = 4'h3;
  localparam logic [3:0] REG_PEAK16   = 4'h4;
  localparam logic [3:0] REG_SCALE_V  = 4'h5;
  localparam logic [3:0] REG_SCALE_I  = 4'h6;
  localparam logic [3:0] REG_RAMP     = 4'h7;
  localparam logic [3:0] REG_INTREF   = 4'h8;
  localparam logic [3:0] REG_PTC      = 4'h9;
  localparam logic [3:0] REG_REGEN    = 4'hA;
  localparam logic [3:0] REG_STATUS   = 4'hB;
  localparam logic [3:0] REG_IRQ_STAT = 4'hC;
  localparam logic [3:0] REG_IRQ_MASK = 4'hD;
  localparam logic [3:0] REG_TARGET   = 4'hE;
  localparam logic [3:0] REG_POS      = 4'hF;

  // Fields of REG_MODE
  localparam int MODE_LSB      = 0;
  localparam int REF_EXT_BIT   = 2;
  localparam int QUAD_BIT      = 3;
  localparam int RAMP_ON_BIT   = 4;
  localparam int FRST_ENA_BIT  = 5;
  localparam int TEMP_ENA_BIT  = 6;
  localparam int DUAL_BIT      = 7;

  typedef enum logic [1:0] {
    MODE_TORQUE   = 2'h0,
    MODE_VELOCITY = 2'h1,
    MODE_POSITION = 2'h2
  } op_mode_t;

  // Interrupt bits
  localparam int IRQ_FAULT    = 0;
  localparam int IRQ_FOLDBACK = 1;
  localparam int IRQ_OVERTEMP = 2;
  localparam int IRQ_CARR_REJ = 3;
  localparam int IRQ_W        = 4;

  // Percent caps of rated current per carrier
  localparam logic [8:0] CAP_8K_PCT  = 9'h12C;
  localparam logic [8:0] CAP_16K_PCT = 9'h0FA;

  // Timing
  localparam longint CLK_HZ       = 100000000;
  localparam longint PEAK_TIME_MS = 2000;
  localparam longint PEAK_CYCLES  = CLK_HZ / 1000 * PEAK_TIME_MS;
  localparam int     PWM_PERIOD   = 100;

  // Reset values
  localparam logic [15:0] RST_SCALE = 16'h0001;
  localparam logic [7:0]  RST_REGEN = 8'h0A;
endpackage : servo_ctrl_pkg
`default_nettype wire

// ---- hdl/pulse_ref_if.sv ----
// Interface: decoded position pulses from decoder to controller
`default_nettype none
interface pulse_ref_if;
  logic step;
  logic dir_up;
  modport src (output step, output dir_up);
  modport dst (input step, input dir_up);
endinterface : pulse_ref_if
`default_nettype wire

// ---- hdl/pulse_decoder.sv ----
// Step/direction or quadrature decoder with pin synchronisers
`default_nettype none
module pulse_decoder (
  input  wire logic i_clk,     // System clock
  input  wire logic i_resetn,  // Sync reset, active low
  input  wire logic i_ce,      // Clock enable
  input  wire logic i_quad,    // 1: quadrature, 0: step/dir
  input  wire logic i_pin_a,   // Step or phase A pin
  input  wire logic i_pin_b,   // Direction or phase B pin
  pulse_ref_if.src  o_ref      // Decoded count pulses
);
  typedef struct packed {
    logic [2:0] sa;
    logic [2:0] sb;
    logic       a;
    logic       b;
    logic       step;
    logic       up;
  } dec_t;
  dec_t st, next_st;

  always_comb begin
    logic na, nb;
    na = st.a;
    nb = st.b;
    next_st = st;
    next_st.sa = {st.sa[1:0], i_pin_a};
    next_st.sb = {st.sb[1:0], i_pin_b};
    // Accept a level only when stages two and three agree
    if (st.sa[1] == st.sa[2]) na = st.sa[2];
    if (st.sb[1] == st.sb[2]) nb = st.sb[2];
    next_st.a = na;
    next_st.b = nb;
    next_st.step = 1'b0;
    if (i_quad) begin
      if ((na ^ st.a) || (nb ^ st.b)) begin
        next_st.step = 1'b1;
        next_st.up = (na ^ st.a) ? (na ^ nb) : ~(na ^ nb);
      end
    end else if (na && !st.a) begin
      next_st.step = 1'b1;
      next_st.up = nb;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) st <= '0;
    else if (i_ce) st <= next_st;
  end

  assign o_ref.step = st.step;
  assign o_ref.dir_up = st.up;
endmodule : pulse_decoder
`default_nettype wire

// ---- hdl/peak_limit_timer.sv ----
// Peak/nominal current limit foldback timer
`default_nettype none
module peak_limit_timer #(
  parameter longint PEAK_CYCLES = servo_ctrl_pkg::PEAK_CYCLES
) (
  input  wire logic        i_clk,      // System clock
  input  wire logic        i_resetn,   // Sync reset, active low
  input  wire logic        i_ce,       // Clock enable
  input  wire logic [15:0] i_current,  // Measured phase current
  input  wire logic [15:0] i_nominal,  // Nominal limit
  output logic             o_folded    // 1: nominal limit active
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        folded;
  } tmr_t;
  tmr_t st, next_st;
  localparam logic [31:0] LAST = 32'(PEAK_CYCLES - 1);

  always_comb begin
    next_st = st;
    if (!st.folded) begin
      if (i_current > i_nominal) begin
        next_st.cnt = st.cnt + 32'h1;
        if (st.cnt >= LAST) begin
          next_st.folded = 1'b1;
          next_st.cnt = '0;
        end
      end else next_st.cnt = '0;
    end else begin
      if (i_current < i_nominal) begin
        next_st.cnt = st.cnt + 32'h1;
        if (st.cnt >= LAST) begin
          next_st.folded = 1'b0;
          next_st.cnt = '0;
        end
      end else next_st.cnt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) st <= '0;
    else if (i_ce) st <= next_st;
  end

  assign o_folded = st.folded;
endmodule : peak_limit_timer
`default_nettype wire

// ---- hdl/servo_mode_reference_limit_ctrl.sv ----
// Servo mode, reference, current limit, fault and regen control
//
// Local design decisions: strobed register access and the register offsets.
`default_nettype none
// Summary of operation
// - Exactly one of torque, velocity, position modes is active.
// - External velocity target equals analog input times velocity scale.
// - External torque target equals analog input times current scale.
// - Reference selector picks external pins or internal variables.
// - Analog feeds torque/velocity; pulses feed position mode.
// - Setting chooses step-direction or quadrature pulse decoding.
// - Internal position target comes from trajectory generator.
// - Carrier frequency changes accepted only while drive disabled.
// - Overload capped at 300 percent at 8 kHz, 250 at 16.
// - Peak current allowed two seconds, then nominal limit applies.
// - Two seconds below nominal restores the peak limit.
// - Separate peak limits per carrier; only matching one applies.
// - Ramp limit off gives max rate; on uses ramp times in velocity mode only.
// - Clear-on-disable policy clears latched fault at disable.
// - Clear-on-enable policy holds fault until next enable.
// - Over-temperature check when enabled: thermistor vs cut-off.
// - Second-encoder setting selects dual-loop, else single loop.
// - Braking switch duty limited to configured maximum percent.
module servo_mode_reference_limit_ctrl #(
  parameter longint PEAK_CYCLES = servo_ctrl_pkg::PEAK_CYCLES
) (
  input  wire logic        i_clk,                    // 100 MHz clock
  input  wire logic        i_resetn,                 // Sync reset, low
  input  wire logic        i_ce,                     // Clock enable
  input  wire logic [3:0]  i_addr,                   // Register index
  input  wire logic [31:0] i_wdata,                  // Write data
  input  wire logic        i_wr,                     // Write strobe
  input  wire logic        i_rd,                     // Read strobe
  output logic [31:0]      o_rdata,                  // Read data
  output logic             o_irq,                    // Interrupt level
  input  wire logic        i_enable,                 // Drive enable
  input  wire logic        i_fault,                  // Fault event
  input  wire logic [15:0] i_analog_reference_input, // Signed mV sample
  input  wire logic        i_step_a,                 // Step / phase A
  input  wire logic        i_dir_b,                  // Dir / phase B
  input  wire logic [31:0] i_traj_pos,               // Trajectory target
  input  wire logic [15:0] i_current,                // Phase current
  input  wire logic [15:0] i_speed,                  // Signed speed
  input  wire logic [15:0] i_ptc_ohm,                // Thermistor ohms
  input  wire logic        i_regen_req,              // Braking wanted
  output logic [1:0]       o_mode,                   // Active mode
  output logic [31:0]      o_target,                 // Speed/current/pos
  output logic [15:0]      o_current_limit,          // Active limit
  output logic             o_carrier_16k,            // 1: 16 kHz
  output logic             o_fault,                  // Latched fault
  output logic             o_overtemp,               // Over-temperature
  output logic             o_dual_loop,              // Dual loop select
  output logic             o_brake_sw                // Braking switch
);
  localparam int IRQ_W_L = servo_ctrl_pkg::IRQ_W;

  typedef struct packed {
    logic [7:0]  mode_cfg;
    logic        carrier;
    logic [15:0] ilim;
    logic [15:0] peak8;
    logic [15:0] peak16;
    logic [15:0] rated;
    logic [15:0] scale_v;
    logic [15:0] scale_i;
    logic [15:0] ramp_up;
    logic [15:0] ramp_dn;
    logic [31:0] intref;
    logic [15:0] ptc_cut;
    logic [7:0]  regen;
    logic [IRQ_W_L-1:0] irq_stat;
    logic [IRQ_W_L-1:0] irq_mask;
    logic [31:0] rdata;
    logic [31:0] target;
    logic [31:0] pos;
    logic [15:0] ramp_cnt;
    logic [15:0] limit;
    logic        fault;
    logic        ena_d;
    logic        overtemp;
    logic [6:0]  pwm_cnt;
    logic        brake;
    logic        irq;
    logic        folded_d;
  } ctl_t;

  ctl_t st, next_st;
  pulse_ref_if pref ();
  logic folded;

  pulse_decoder u_dec (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_quad   (st.mode_cfg[servo_ctrl_pkg::QUAD_BIT]),
    .i_pin_a  (i_step_a),
    .i_pin_b  (i_dir_b),
    .o_ref    (pref.src)
  );

  peak_limit_timer #(.PEAK_CYCLES(PEAK_CYCLES)) u_peak (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_ce      (i_ce),
    .i_current (i_current),
    .i_nominal (st.ilim),
    .o_folded  (folded)
  );

  always_comb begin
    logic [1:0]         mode;
    logic               ext;
    logic [31:0]        prod;
    logic [31:0]        ain32;
    logic [31:0]        goal;
    logic [15:0]        peak;
    logic [24:0]        cap;
    logic [IRQ_W_L-1:0] ev;
    logic [IRQ_W_L-1:0] clr;
    mode = st.mode_cfg[1:0];
    ext  = st.mode_cfg[servo_ctrl_pkg::REF_EXT_BIT];
    prod = '0;
    // Full-width signed product, no 16-bit wrap
    ain32 = {{16{i_analog_reference_input[15]}},
             i_analog_reference_input};
    goal = st.target;
    peak = '0;
    cap  = '0;
    ev   = '0;
    clr  = '0;
    next_st = st;

    // Register writes
    if (i_wr) begin
      unique case (i_addr)
        servo_ctrl_pkg::REG_MODE: begin
          // Illegal mode code falls back to torque
          next_st.mode_cfg = i_wdata[7:0];
          if (i_wdata[1:0] == 2'h3) next_st.mode_cfg[1:0] = 2'h0;
        end
        servo_ctrl_pkg::REG_CARRIER: begin
          if (!i_enable) next_st.carrier = i_wdata[0];
          else ev[servo_ctrl_pkg::IRQ_CARR_REJ] = 1'b1;
        end
        servo_ctrl_pkg::REG_ILIM: begin
          next_st.ilim  = i_wdata[15:0];
          next_st.rated = i_wdata[31:16];
        end
        servo_ctrl_pkg::REG_PEAK8:   next_st.peak8   = i_wdata[15:0];
        servo_ctrl_pkg::REG_PEAK16:  next_st.peak16  = i_wdata[15:0];
        servo_ctrl_pkg::REG_SCALE_V: next_st.scale_v = i_wdata[15:0];
        servo_ctrl_pkg::REG_SCALE_I: next_st.scale_i = i_wdata[15:0];
        servo_ctrl_pkg::REG_RAMP: begin
          next_st.ramp_up = i_wdata[15:0];
          next_st.ramp_dn = i_wdata[31:16];
        end
        servo_ctrl_pkg::REG_INTREF:  next_st.intref  = i_wdata;
        servo_ctrl_pkg::REG_PTC:     next_st.ptc_cut = i_wdata[15:0];
        servo_ctrl_pkg::REG_REGEN: begin
          next_st.regen = (i_wdata[7:0] > 8'h64) ? 8'h64 : i_wdata[7:0];
        end
        servo_ctrl_pkg::REG_IRQ_STAT: clr = i_wdata[IRQ_W_L-1:0];
        servo_ctrl_pkg::REG_IRQ_MASK: begin
          next_st.irq_mask = i_wdata[IRQ_W_L-1:0];
        end
        default: ;
      endcase
    end

    // Reads: data in the following cycle only
    next_st.rdata = '0;
    if (i_rd) begin
      unique case (i_addr)
        servo_ctrl_pkg::REG_MODE:     next_st.rdata = {24'h0, st.mode_cfg};
        servo_ctrl_pkg::REG_CARRIER:  next_st.rdata = {31'h0, st.carrier};
        servo_ctrl_pkg::REG_ILIM:     next_st.rdata = {st.rated, st.ilim};
        servo_ctrl_pkg::REG_PEAK8:    next_st.rdata = {16'h0, st.peak8};
        servo_ctrl_pkg::REG_PEAK16:   next_st.rdata = {16'h0, st.peak16};
        servo_ctrl_pkg::REG_SCALE_V:  next_st.rdata = {16'h0, st.scale_v};
        servo_ctrl_pkg::REG_SCALE_I:  next_st.rdata = {16'h0, st.scale_i};
        servo_ctrl_pkg::REG_RAMP:   next_st.rdata = {st.ramp_dn, st.ramp_up};
        servo_ctrl_pkg::REG_INTREF:   next_st.rdata = st.intref;
        servo_ctrl_pkg::REG_PTC:      next_st.rdata = {16'h0, st.ptc_cut};
        servo_ctrl_pkg::REG_REGEN:    next_st.rdata = {24'h0, st.regen};
        servo_ctrl_pkg::REG_STATUS: begin
          next_st.rdata = {16'h0, st.limit[7:0], 3'h0, folded,
                           st.overtemp, st.fault, i_enable, 1'b0};
        end
        servo_ctrl_pkg::REG_IRQ_STAT: begin
          next_st.rdata = {{(32-IRQ_W_L){1'b0}}, st.irq_stat};
        end
        servo_ctrl_pkg::REG_IRQ_MASK: begin
          next_st.rdata = {{(32-IRQ_W_L){1'b0}}, st.irq_mask};
        end
        servo_ctrl_pkg::REG_TARGET:   next_st.rdata = st.target;
        servo_ctrl_pkg::REG_POS:      next_st.rdata = st.pos;
        default:                      next_st.rdata = '0;
      endcase
    end

    if (pref.step) begin
      next_st.pos = pref.dir_up ? st.pos + 32'h1 : st.pos - 32'h1;
    end

    unique case (mode)
      servo_ctrl_pkg::MODE_TORQUE: begin
        // Set current = volts x A/V
        prod = $signed(ain32) * $signed({{16{st.scale_i[15]}}, st.scale_i});
        goal = ext ? prod : st.intref;
      end
      servo_ctrl_pkg::MODE_VELOCITY: begin
        // Set speed = volts x RPM/V
        prod = $signed(ain32) * $signed({{16{st.scale_v[15]}}, st.scale_v});
        goal = ext ? prod : st.intref;
      end
      default: begin
        goal = ext ? st.pos : i_traj_pos;
      end
    endcase

    // Ramp: one step per ramp-time count
    if (mode == 2'(servo_ctrl_pkg::MODE_VELOCITY)
        && st.mode_cfg[servo_ctrl_pkg::RAMP_ON_BIT]
        && goal != st.target) begin
      next_st.ramp_cnt = st.ramp_cnt + 16'h1;
      if ($signed(goal) > $signed(st.target)) begin
        if (st.ramp_cnt >= st.ramp_up) begin
          next_st.ramp_cnt = '0;
          next_st.target = st.target + 32'h1;
        end
      end else if (st.ramp_cnt >= st.ramp_dn) begin
        next_st.ramp_cnt = '0;
        next_st.target = st.target - 32'h1;
      end
    end else begin
      next_st.ramp_cnt = '0;
      next_st.target = goal;
    end

    // Peak setting of the active carrier
    peak = st.carrier ? st.peak16 : st.peak8;
    // Overload cap in percent of rated
    cap = st.carrier ? 25'(st.rated) * 25'(servo_ctrl_pkg::CAP_16K_PCT)
                     : 25'(st.rated) * 25'(servo_ctrl_pkg::CAP_8K_PCT);
    if ({9'h0, peak} * 25'd100 > cap) peak = 16'(cap / 25'd100);
    next_st.limit = folded ? st.ilim : peak;
    next_st.folded_d = folded;
    if (folded && !st.folded_d) ev[servo_ctrl_pkg::IRQ_FOLDBACK] = 1'b1;

    // Fault latch and clearing policy
    next_st.ena_d = i_enable;
    if (st.mode_cfg[servo_ctrl_pkg::FRST_ENA_BIT]) begin
      if (i_enable && !st.ena_d) next_st.fault = 1'b0;
    end else if (!i_enable) begin
      next_st.fault = 1'b0;
    end
    if (i_fault || st.overtemp) begin
      next_st.fault = 1'b1;
      ev[servo_ctrl_pkg::IRQ_FAULT] = 1'b1;
    end

    next_st.overtemp = st.mode_cfg[servo_ctrl_pkg::TEMP_ENA_BIT]
                       && (i_ptc_ohm > st.ptc_cut);
    if (next_st.overtemp && !st.overtemp) begin
      ev[servo_ctrl_pkg::IRQ_OVERTEMP] = 1'b1;
    end

    // Duty limited over a 100-cycle frame
    next_st.pwm_cnt = (st.pwm_cnt == 7'(servo_ctrl_pkg::PWM_PERIOD - 1))
                      ? 7'h0 : st.pwm_cnt + 7'h1;
    next_st.brake = i_regen_req && ({1'b0, st.pwm_cnt} < st.regen);

    // Set wins over clear
    next_st.irq_stat = (st.irq_stat & ~clr) | ev;
    next_st.irq = |(next_st.irq_stat & st.irq_mask);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st <= '0;
      st.scale_v <= servo_ctrl_pkg::RST_SCALE;
      st.scale_i <= servo_ctrl_pkg::RST_SCALE;
      st.regen   <= servo_ctrl_pkg::RST_REGEN;
      st.mode_cfg[servo_ctrl_pkg::REF_EXT_BIT] <= 1'b1;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_rdata         = st.rdata;
  assign o_irq           = st.irq;
  assign o_mode          = st.mode_cfg[1:0];
  assign o_target        = st.target;
  assign o_current_limit = st.limit;
  assign o_carrier_16k   = st.carrier;
  assign o_fault         = st.fault;
  assign o_overtemp      = st.overtemp;
  assign o_dual_loop     = st.mode_cfg[servo_ctrl_pkg::DUAL_BIT];
  assign o_brake_sw      = st.brake;
endmodule : servo_mode_reference_limit_ctrl
`default_nettype wire

// ---- tb/ref_source_model.sv ----
// Reference source: analog level and step/direction or quadrature pins
`default_nettype none
module ref_source_model (
  input  wire logic   i_clk,   // System clock
  output logic [15:0] o_level, // Analog sample
  output logic        o_pin_a, // Step or phase A
  output logic        o_pin_b  // Direction or phase B
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_level = 16'h0000;
    o_pin_a = 1'b0;
    o_pin_b = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
  endtask : hold
  task automatic set_level(input logic [15:0] v);
    @(posedge i_clk);
    o_level <= v;
  endtask : set_level
  task automatic steps(input int n, input logic up);
    @(posedge i_clk);
    o_pin_b <= up;
    // Direction settles before the first step edge
    hold(4);
    repeat (n) begin
      o_pin_a <= 1'b1;
      hold(4);
      o_pin_a <= 1'b0;
      hold(4);
    end
  endtask : steps
  task automatic quad_cycle();
    @(posedge i_clk);
    o_pin_a <= 1'b1;
    hold(4);
    o_pin_b <= 1'b1;
    hold(4);
    o_pin_a <= 1'b0;
    hold(4);
    o_pin_b <= 1'b0;
    hold(4);
  endtask : quad_cycle
endmodule : ref_source_model
`default_nettype wire

// ---- tb/servo_ctrl_monitor.sv ----
// Port-level assertions for the servo control block
`default_nettype none
module servo_ctrl_monitor #(
  parameter longint PEAK_CYCLES = 20
) (
  input wire logic        i_clk,         // Clock
  input wire logic        i_resetn,      // Reset, low
  input wire logic [3:0]  i_addr,        // Index
  input wire logic        i_wr,          // Write
  input wire logic        i_rd,          // Read
  input wire logic [31:0] o_rdata,       // Read data
  input wire logic        i_enable,      // Enable
  input wire logic        i_fault,       // Fault event
  input wire logic        i_regen_req,   // Brake wanted
  input wire logic [1:0]  o_mode,        // Mode
  input wire logic        o_carrier_16k, // Carrier
  input wire logic        o_fault,       // Fault
  input wire logic        o_overtemp,    // Hot
  input wire logic        o_dual_loop,   // Dual loop
  input wire logic        o_brake_sw     // Brake switch
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its slot");
  a_mode_one_legal: assert property (o_mode != 2'h3)
    else $error("illegal mode code");
  a_carrier_hold_enabled: assert property
    (i_enable && $past(i_enable) |-> $stable(o_carrier_16k))
    else $error("carrier changed while enabled");
  a_carrier_by_write: assert property ($changed(o_carrier_16k) |->
    $past(i_wr) && $past(i_addr) == servo_ctrl_pkg::REG_CARRIER
    && !$past(i_enable))
    else $error("carrier changed without legal write");
  a_dual_by_write: assert property ($changed(o_dual_loop) |->
    $past(i_wr) && $past(i_addr) == servo_ctrl_pkg::REG_MODE)
    else $error("dual loop changed without write");
  a_brake_needs_req: assert property
    (!i_regen_req ##1 !i_regen_req |-> !o_brake_sw)
    else $error("brake on without request");
  a_fault_latch_set: assert property (i_fault |=> o_fault)
    else $error("fault event not latched");
  a_fault_enable_clear: assert property ($rose(i_enable) && !i_fault
    && !$past(i_fault) && !o_overtemp |=> !o_fault)
    else $error("fault still set after enable");
endmodule : servo_ctrl_monitor
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the servo control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint PEAK_CYCLES = 20;
  logic i_clk, i_resetn, i_ce, i_wr, i_rd, i_enable, i_fault, i_regen_req;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, i_traj_pos, o_rdata, o_target, v, w;
  logic [15:0] i_analog_reference_input, i_current, i_ptc_ohm;
  logic [15:0] o_current_limit;
  logic [1:0] o_mode;
  logic i_step_a, i_dir_b, o_irq, o_carrier_16k, o_fault, o_overtemp;
  logic o_dual_loop, o_brake_sw;
  int fail_count, samples_checked, n;

  servo_mode_reference_limit_ctrl #(.PEAK_CYCLES(PEAK_CYCLES))
      u_servo_mode_reference_limit_ctrl (
    .i_clk, .i_resetn, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_irq, .i_enable, .i_fault, .i_analog_reference_input,
    .i_step_a, .i_dir_b, .i_traj_pos, .i_current, .i_speed(16'h0000),
    .i_ptc_ohm, .i_regen_req, .o_mode, .o_target, .o_current_limit,
    .o_carrier_16k, .o_fault, .o_overtemp, .o_dual_loop, .o_brake_sw);
  ref_source_model u_ref_source_model (.i_clk,
    .o_level(i_analog_reference_input), .o_pin_a(i_step_a),
    .o_pin_b(i_dir_b));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] got);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 got = o_rdata;
  endtask : rd
  task automatic settle(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic results();
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial begin
    #300000;
    fail_count++;
    results();
  end

  initial begin
    {i_resetn, i_wr, i_rd, i_enable, i_fault, i_regen_req} = 6'h00;
    {i_addr, i_wdata, i_traj_pos} = 68'h0;
    {i_current, i_ptc_ohm} = 32'h0;
    i_ce = 1'b1;
    fail_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(servo_ctrl_pkg::REG_SCALE_V, v);
    chk(v, 32'h1);
    rd(servo_ctrl_pkg::REG_REGEN, v);
    chk(v, 32'hA);
    u_ref_source_model.set_level(16'h00FA);
    wr(servo_ctrl_pkg::REG_SCALE_V, 32'hC8);
    wr(servo_ctrl_pkg::REG_MODE, 32'h5);
    settle(3);
    chk(o_target, 32'hC350);
    chk(32'(o_mode), 32'h1);
    u_ref_source_model.set_level(16'hFFFC);
    wr(servo_ctrl_pkg::REG_SCALE_I, 32'h3);
    wr(servo_ctrl_pkg::REG_MODE, 32'h4);
    settle(3);
    chk(o_target, 32'hFFFFFFF4);
    wr(servo_ctrl_pkg::REG_INTREF, 32'h1234);
    wr(servo_ctrl_pkg::REG_MODE, 32'h1);
    settle(3);
    chk(o_target, 32'h1234);
    @(posedge i_clk) i_traj_pos <= 32'hABCD0;
    wr(servo_ctrl_pkg::REG_MODE, 32'h2);
    settle(3);
    chk(o_target, 32'hABCD0);
    wr(servo_ctrl_pkg::REG_MODE, 32'h3);
    settle(2);
    chk(32'(o_mode), 32'h0);
    // Ramp on, then step the analog level
    u_ref_source_model.set_level(16'h0000);
    wr(servo_ctrl_pkg::REG_RAMP, 32'h00030003);
    // Start the ramp from a zero target
    wr(servo_ctrl_pkg::REG_MODE, 32'h5);
    wr(servo_ctrl_pkg::REG_MODE, 32'h15);
    u_ref_source_model.set_level(16'h0005);
    settle(8);
    chk(o_target, 32'h2);
    wr(servo_ctrl_pkg::REG_MODE, 32'h5);
    settle(3);
    chk(o_target, 32'h3E8);
    wr(servo_ctrl_pkg::REG_MODE, 32'h6);
    u_ref_source_model.steps(5, 1'b1);
    rd(servo_ctrl_pkg::REG_POS, v);
    u_ref_source_model.steps(2, 1'b0);
    rd(servo_ctrl_pkg::REG_POS, w);
    chk(v - w, 32'h2);
    wr(servo_ctrl_pkg::REG_MODE, 32'hE);
    u_ref_source_model.quad_cycle();
    rd(servo_ctrl_pkg::REG_POS, v);
    chk(32'(v - w == 32'h4 || w - v == 32'h4), 32'h1);
    wr(servo_ctrl_pkg::REG_ILIM, 32'h00640032);
    wr(servo_ctrl_pkg::REG_PEAK8, 32'h190);
    wr(servo_ctrl_pkg::REG_PEAK16, 32'h12C);
    settle(2);
    chk(32'(o_current_limit), 32'h12C);
    wr(servo_ctrl_pkg::REG_CARRIER, 32'h1);
    settle(2);
    chk(32'(o_current_limit), 32'hFA);
    wr(servo_ctrl_pkg::REG_PEAK16, 32'h64);
    @(posedge i_clk) i_enable <= 1'b1;
    wr(servo_ctrl_pkg::REG_CARRIER, 32'h0);
    settle(2);
    chk(32'(o_current_limit), 32'h64);
    chk(32'(o_carrier_16k), 32'h1);
    rd(servo_ctrl_pkg::REG_IRQ_STAT, v);
    chk(v, 32'h8);
    chk(32'(o_irq), 32'h0);
    wr(servo_ctrl_pkg::REG_IRQ_MASK, 32'h8);
    settle(2);
    chk(32'(o_irq), 32'h1);
    wr(servo_ctrl_pkg::REG_IRQ_STAT, 32'h8);
    settle(2);
    chk(32'(o_irq), 32'h0);
    // Foldback then recovery, both spans PEAK_CYCLES long
    @(posedge i_clk) i_current <= 16'h003C;
    settle(10);
    chk(32'(o_current_limit), 32'h64);
    settle(20);
    chk(32'(o_current_limit), 32'h32);
    @(posedge i_clk) i_current <= 16'h000A;
    settle(10);
    chk(32'(o_current_limit), 32'h32);
    settle(20);
    chk(32'(o_current_limit), 32'h64);
    wr(servo_ctrl_pkg::REG_MODE, 32'h4);
    @(posedge i_clk) i_fault <= 1'b1;
    @(posedge i_clk) i_fault <= 1'b0;
    settle(3);
    chk(32'(o_fault), 32'h1);
    @(posedge i_clk) i_enable <= 1'b0;
    settle(2);
    chk(32'(o_fault), 32'h0);
    wr(servo_ctrl_pkg::REG_MODE, 32'h24);
    @(posedge i_clk) i_enable <= 1'b1;
    @(posedge i_clk) i_fault <= 1'b1;
    @(posedge i_clk) i_fault <= 1'b0;
    @(posedge i_clk) i_enable <= 1'b0;
    settle(3);
    chk(32'(o_fault), 32'h1);
    @(posedge i_clk) i_enable <= 1'b1;
    settle(2);
    chk(32'(o_fault), 32'h0);
    wr(servo_ctrl_pkg::REG_PTC, 32'h3E8);
    @(posedge i_clk) i_ptc_ohm <= 16'h05DC;
    settle(3);
    chk(32'(o_overtemp), 32'h0);
    wr(servo_ctrl_pkg::REG_MODE, 32'h64);
    settle(3);
    chk(32'(o_overtemp), 32'h1);
    @(posedge i_clk) i_ptc_ohm <= 16'h01F4;
    settle(3);
    chk(32'(o_overtemp), 32'h0);
    wr(servo_ctrl_pkg::REG_MODE, 32'h86);
    settle(2);
    chk(32'(o_dual_loop), 32'h1);
    wr(servo_ctrl_pkg::REG_MODE, 32'h6);
    settle(2);
    chk(32'(o_dual_loop), 32'h0);
    // Frozen clock enable must drop the write
    @(posedge i_clk) i_ce <= 1'b0;
    wr(servo_ctrl_pkg::REG_MODE, 32'h86);
    settle(2);
    chk(32'(o_dual_loop), 32'h0);
    @(posedge i_clk) i_ce <= 1'b1;
    wr(servo_ctrl_pkg::REG_REGEN, 32'h19);
    @(posedge i_clk) i_regen_req <= 1'b1;
    settle(3);
    n = 0;
    repeat (200) begin
      settle(1);
      n += (o_brake_sw === 1'b1) ? 1 : 0;
    end
    chk(32'(n), 32'h32);
    @(posedge i_clk) i_regen_req <= 1'b0;
    wr(servo_ctrl_pkg::REG_REGEN, 32'hC8);
    rd(servo_ctrl_pkg::REG_REGEN, v);
    chk(v, 32'h64);
    results();
  end
endmodule : testbench

bind servo_mode_reference_limit_ctrl servo_ctrl_monitor #(
  .PEAK_CYCLES(PEAK_CYCLES)) u_servo_ctrl_monitor (.i_clk, .i_resetn,
  .i_addr, .i_wr, .i_rd, .o_rdata, .i_enable, .i_fault, .i_regen_req,
  .o_mode, .o_carrier_16k, .o_fault, .o_overtemp, .o_dual_loop,
  .o_brake_sw);
`default_nettype wire
